// >>> hw/cps_map.vh
// Purpose: Constants for the charger protection and power-path selector.
// Assumes: One 200 MHz clock; comparator flags arrive synchronous to it.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
`ifndef CPS_MAP_VH
`define CPS_MAP_VH

`define CPS_CLK_KHZ        200000
`define CPS_TICK_US        1000
`define CPS_TICK_CYC       ((`CPS_CLK_KHZ * `CPS_TICK_US) / 1000)
`define CPS_INSERT_MS      700
`define CPS_BLANK_MS       2
`define CPS_RAMP_STEPS     8
`define CPS_RAMP_STEP_MS   1

`define CPS_OFF_CTRL       32'h0000_0000
`define CPS_OFF_STATUS     32'h0000_0004
`define CPS_OFF_FLAGS      32'h0000_0008
`define CPS_OFF_RAMP       32'h0000_000c
`define CPS_ADDR_MSB       4

`define CPS_CTRL_CHG_EN    0
`define CPS_CTRL_CALIB     1
`define CPS_CTRL_RESET     32'h0000_0000

`define CPS_ST_ACSW        0
`define CPS_ST_BATSW       1
`define CPS_ST_CHG         2
`define CPS_ST_GOOD        3
`define CPS_ST_OVP_LATCH   4
`define CPS_ST_BSHORT      5
`define CPS_ST_HSIDE       6
`define CPS_ST_BBM         7

`endif

// >>> hw/cps_selector.v
// Purpose: Protection and power-path selector logic of a battery charger.
// Assumes: All comparator flags are synchronous to hclk; hresetn is the lockout.
// Notes:   Register access over AHB-Lite, zero wait states, OKAY always.
`timescale 1ns/1ps
`default_nettype none
`include "cps_map.vh"

module cps_selector #(
	parameter INSERT_MS = `CPS_INSERT_MS,
	parameter BLANK_MS  = `CPS_BLANK_MS,
	parameter TICK_CYC  = `CPS_TICK_CYC
) (
	// Clock and reset (reset is the supply lockout)
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// Comparator flags
	input  wire        supply_rail_ok,
	input  wire        adapter_detect_low,
	input  wire        adapter_detect_good,
	input  wire        input_overvoltage,
	input  wire        input_low_clear,
	input  wire        battery_over_104,
	input  wire        battery_below_102,
	input  wire        battery_short_in,
	input  wire        charge_overcurrent,
	input  wire        thermal_shutdown,
	input  wire        thermal_below_135,
	input  wire        input_current_limit,
	input  wire        overpower_cap_2v,
	// Power-path and status outputs
	output reg         adapter_switch_drive,
	output reg         battery_switch_drive,
	output reg         charge_enable,
	output reg         hside_gate_enable,
	output reg         precharge_scale,
	output reg         battery_short_flag,
	output reg         discharge_sink_en,
	output reg         overpower_charge_src,
	output reg         overpower_sink_en,
	output reg         input_current_monitor_out,
	output reg         bias_enable,
	output reg  [3:0]  charge_target_step,
	output reg         adapter_good_n_out,
	output reg         adapter_good_n_oe_n
);

	// ==========================================================
	// Millisecond timebase
	// ==========================================================
	localparam [31:0] TICK_LAST = TICK_CYC - 1;
	// A free-running divider: a delay may start anywhere inside a tick, so it can run up to one tick short.
	reg  [31:0] tick_cnt_q;
	wire        ms_tick = (tick_cnt_q == TICK_LAST);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tick_cnt_q <= 32'h0000_0000;
		else if (ms_tick)
			tick_cnt_q <= 32'h0000_0000;
		else
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
	end

	// ==========================================================
	// Register file
	// ==========================================================
	reg         ctrl_chg_q;
	reg         ctrl_calib_q;
	reg         wr_pend_q;
	reg  [31:0] wr_addr_q;
	wire        addr_ok = hsel && hready && htrans[1];
	reg  [31:0] rd_addr_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q    <= 1'b0;
			wr_addr_q    <= 32'h0000_0000;
			rd_addr_q    <= 32'h0000_0000;
			ctrl_chg_q   <= 1'b0;
			ctrl_calib_q <= 1'b0;
		end else begin
			wr_pend_q <= addr_ok && hwrite;
			if (addr_ok) begin
				wr_addr_q <= haddr;
				rd_addr_q <= haddr;
			end
			if (wr_pend_q && wr_addr_q[`CPS_ADDR_MSB:0] == `CPS_OFF_CTRL) begin
				ctrl_chg_q   <= hwdata[`CPS_CTRL_CHG_EN];
				ctrl_calib_q <= hwdata[`CPS_CTRL_CALIB];
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ==========================================================
	// Insertion sequence
	// ==========================================================
	localparam [3:0] S_IDLE  = 4'h1;
	localparam [3:0] S_WAIT  = 4'h2;
	localparam [3:0] S_BLANK = 4'h4;
	localparam [3:0] S_RUN   = 4'h8;

	reg  [3:0]  state_q;
	reg  [3:0]  state_d;
	reg  [15:0] ms_cnt_q;
	reg  [15:0] ms_cnt_d;
	reg         overpower_q;
	reg         bbm_q;
	reg         good_prev_q;
	wire        good_rise = adapter_detect_good && !good_prev_q;

	always @* begin
		state_d  = state_q;
		ms_cnt_d = ms_cnt_q;
		case (state_q)
			S_IDLE: begin
				ms_cnt_d = 16'h0000;
				if (adapter_detect_good && supply_rail_ok)
					state_d = S_WAIT;
			end
			S_WAIT: begin
				if (ms_tick)
					ms_cnt_d = ms_cnt_q + 16'h0001;
				if (ms_tick && ms_cnt_q == INSERT_MS[15:0] - 16'h0001) begin
					state_d  = S_BLANK;
					ms_cnt_d = 16'h0000;
				end
			end
			S_BLANK: begin
				if (ms_tick)
					ms_cnt_d = ms_cnt_q + 16'h0001;
				if (ms_tick && ms_cnt_q == BLANK_MS[15:0] - 16'h0001)
					state_d = S_RUN;
			end
			S_RUN: ms_cnt_d = 16'h0000;
			default: state_d = S_IDLE;
		endcase
		if (!adapter_detect_good || !supply_rail_ok)
			state_d = S_IDLE;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q     <= S_IDLE;
			ms_cnt_q    <= 16'h0000;
			good_prev_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			ms_cnt_q    <= ms_cnt_d;
			good_prev_q <= adapter_detect_good;
		end
	end

	// ==========================================================
	// Protection latches
	// ==========================================================
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overpower_q <= 1'b0;
			bbm_q       <= 1'b0;
		end else begin
			// Clearing waits for a new insertion edge or a supply rail drop, so a held fault stays latched.
			if (good_rise || !supply_rail_ok)
				overpower_q <= 1'b0;
			else if (state_q == S_RUN && overpower_cap_2v)
				overpower_q <= 1'b1;
			// Low adapter sense wins over a drive still on, so the flag clears even while the adapter switch is driven.
			if (input_low_clear || !supply_rail_ok)
				bbm_q <= 1'b0;
			else if (adapter_switch_drive)
				bbm_q <= 1'b1;
		end
	end

	// ==========================================================
	// Charger protections
	// ==========================================================
	reg bat_ov_q;
	reg therm_q;
	reg short_q;
	reg calib_swap_q;
	reg [2:0] ramp_q;
	reg [9:0] ramp_ms_q;
	wire adapter_ok = (state_q == S_BLANK || state_q == S_RUN) && !overpower_q && !input_overvoltage;
	wire chg_allow = ctrl_chg_q && adapter_ok && supply_rail_ok && !thermal_shutdown && !therm_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bat_ov_q     <= 1'b0;
			therm_q      <= 1'b0;
			short_q      <= 1'b0;
			calib_swap_q <= 1'b0;
			ramp_q       <= 3'h0;
			ramp_ms_q    <= 10'h000;
		end else begin
			if (battery_over_104)
				bat_ov_q <= 1'b1;
			else if (battery_below_102)
				bat_ov_q <= 1'b0;
			if (thermal_shutdown)
				therm_q <= 1'b1;
			else if (thermal_below_135)
				therm_q <= 1'b0;
			short_q <= battery_short_in;
			// Calibration swaps to the adapter on a short and back on recovery.
			calib_swap_q <= ctrl_calib_q && battery_short_in;
			if (!chg_allow) begin
				ramp_q    <= 3'h0;
				ramp_ms_q <= 10'h000;
			end else if (ms_tick && ramp_q != 3'h7) begin
				if (ramp_ms_q == `CPS_RAMP_STEP_MS - 1) begin
					ramp_ms_q <= 10'h000;
					ramp_q    <= ramp_q + 3'h1;
				end else
					ramp_ms_q <= ramp_ms_q + 10'h001;
			end
		end
	end

	// ==========================================================
	// Output stage: power-path drives
	// ==========================================================
	wire to_adapter = adapter_ok && (!ctrl_calib_q || calib_swap_q);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			adapter_switch_drive <= 1'b0;
			battery_switch_drive <= 1'b0;
		end else begin
			// Battery switch drops before the adapter switch is allowed on, so both never conduct.
			battery_switch_drive <= supply_rail_ok && !input_low_clear && !to_adapter;
			adapter_switch_drive <= supply_rail_ok && to_adapter && !battery_switch_drive;
		end
	end

	// ==========================================================
	// Output stage: charger controls
	// ==========================================================
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			charge_enable      <= 1'b0;
			discharge_sink_en  <= 1'b0;
			hside_gate_enable  <= 1'b0;
			precharge_scale    <= 1'b0;
			battery_short_flag <= 1'b0;
			charge_target_step <= 4'h0;
		end else begin
			charge_enable <= chg_allow;
			discharge_sink_en <= chg_allow;
			// The raw flag gates too, so the first overvoltage cycle is not lost to the latch delay.
			hside_gate_enable <= chg_allow && !bat_ov_q && !battery_over_104 && !charge_overcurrent;
			precharge_scale <= short_q;
			battery_short_flag <= short_q;
			charge_target_step <= chg_allow ? {1'b0, ramp_q} + 4'h1 : 4'h0;
		end
	end

	// ==========================================================
	// Output stage: bias, monitor and status pin
	// ==========================================================
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bias_enable               <= 1'b0;
			input_current_monitor_out <= 1'b0;
			overpower_charge_src      <= 1'b0;
			overpower_sink_en         <= 1'b0;
			adapter_good_n_out        <= 1'b0;
			adapter_good_n_oe_n       <= 1'b1;
		end else begin
			bias_enable <= supply_rail_ok;
			input_current_monitor_out <= supply_rail_ok && !adapter_detect_low;
			// Source and sink follow the limit flag alone, so the capacitor keeps its memory of faults.
			overpower_charge_src <= input_current_limit;
			overpower_sink_en <= !input_current_limit;
			// The pin is open drain: only the enable moves, the driven level is always low.
			adapter_good_n_out <= 1'b0;
			adapter_good_n_oe_n <= !(state_q == S_BLANK || state_q == S_RUN);
		end
	end

	// ==========================================================
	// Read mux
	// ==========================================================
	reg [31:0] rdata;
	always @* begin
		rdata = 32'h0000_0000;
		case (rd_addr_q[`CPS_ADDR_MSB:0])
			`CPS_OFF_CTRL: begin
				rdata[`CPS_CTRL_CHG_EN] = ctrl_chg_q;
				rdata[`CPS_CTRL_CALIB]  = ctrl_calib_q;
			end
			`CPS_OFF_STATUS: begin
				rdata[`CPS_ST_ACSW]       = adapter_switch_drive;
				rdata[`CPS_ST_BATSW]      = battery_switch_drive;
				rdata[`CPS_ST_CHG]        = charge_enable;
				rdata[`CPS_ST_GOOD]       = !adapter_good_n_oe_n;
				rdata[`CPS_ST_OVP_LATCH]  = overpower_q;
				rdata[`CPS_ST_BSHORT]     = battery_short_flag;
				rdata[`CPS_ST_HSIDE]      = hside_gate_enable;
				rdata[`CPS_ST_BBM]        = bbm_q;
			end
			`CPS_OFF_FLAGS: rdata[3:0] = state_q;
			`CPS_OFF_RAMP: rdata[3:0] = charge_target_step;
			default: rdata = 32'h0000_0000;
		endcase
	end
	assign hrdata = rdata;

endmodule // cps_selector
`default_nettype wire

// >>> tb/cps_far_side.sv
// Purpose: Far side of the status pin: pull-up and host reading.
// Assumes: Output enable is low while the device pulls the pin.
// Notes:   A released pin floats to the pull-up, never to the last value.
`timescale 1ns/1ps
`default_nettype none
module cps_far_side (
	// Device side
	input  wire logic good_out,
	input  wire logic good_oe_n,
	// Host side
	output wire logic good_pin
);
	assign good_pin = good_oe_n ? 1'b1 : good_out;
endmodule // cps_far_side
`default_nettype wire

// >>> tb/cps_selector_sva.sv
// Purpose: Port assertions for the protection selector.
// Assumes: Flags are synchronous; each output lags its flags by one cycle, the short flag and precharge scale by two.
// Notes:   Bound to every instance of the selector.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker
module cps_selector_sva (
	// Clock, reset and flags
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic supply_rail_ok,
	input wire logic adapter_detect_low,
	input wire logic input_overvoltage,
	input wire logic input_low_clear,
	input wire logic battery_short_in,
	input wire logic charge_overcurrent,
	input wire logic input_current_limit,
	// Outputs watched
	input wire logic adapter_switch_drive,
	input wire logic battery_switch_drive,
	input wire logic charge_enable,
	input wire logic hside_gate_enable,
	input wire logic battery_short_flag,
	input wire logic overpower_sink_en,
	input wire logic overpower_charge_src,
	input wire logic precharge_scale,
	input wire logic input_current_monitor_out,
	input wire logic bias_enable,
	input wire logic hreadyout,
	input wire logic hresp
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_monitor_gate: assert property (
		input_current_monitor_out |-> $past(supply_rail_ok) && !$past(adapter_detect_low))
		else $error("monitor ungated");
	a_ovp_path: assert property (
		input_overvoltage && supply_rail_ok && !input_low_clear
		|=> !adapter_switch_drive && battery_switch_drive && !charge_enable)
		else $error("overvoltage path wrong");
	a_rail_bias: assert property (
		!supply_rail_ok |=> !bias_enable && !adapter_switch_drive)
		else $error("bias without rail");
	a_low_sense: assert property (
		input_low_clear |=> !battery_switch_drive)
		else $error("battery drive on low sense");
	a_short_flag: assert property (
		battery_short_in |-> ##2 battery_short_flag)
		else $error("short flag missing");
	a_gate_oc: assert property (
		charge_overcurrent |=> !hside_gate_enable)
		else $error("gate on in overcurrent");
	a_no_overlap: assert property (
		!(adapter_switch_drive && battery_switch_drive))
		else $error("both switches on");
	a_bbm_order: assert property (
		$rose(adapter_switch_drive) |-> !$past(battery_switch_drive))
		else $error("adapter on before battery off");
	a_cap_sink: assert property (
		1'b1 |=> overpower_sink_en != $past(input_current_limit))
		else $error("capacitor sink wrong");
	a_short_clear: assert property (
		!battery_short_in |-> ##2 !battery_short_flag && !precharge_scale)
		else $error("short flag stuck");
	a_cap_source: assert property (
		1'b1 |=> overpower_charge_src == $past(input_current_limit))
		else $error("capacitor source wrong");
	a_bus_okay: assert property (
		hreadyout && !hresp)
		else $error("bus not ready or not okay");
endmodule // cps_selector_sva
bind cps_selector cps_selector_sva sva_u (
	.hclk(hclk), .hresetn(hresetn), .supply_rail_ok(supply_rail_ok), .adapter_detect_low(adapter_detect_low),
	.input_overvoltage(input_overvoltage), .input_low_clear(input_low_clear), .battery_short_in(battery_short_in),
	.charge_overcurrent(charge_overcurrent), .input_current_limit(input_current_limit),
	.adapter_switch_drive(adapter_switch_drive), .battery_switch_drive(battery_switch_drive),
	.charge_enable(charge_enable), .hside_gate_enable(hside_gate_enable), .battery_short_flag(battery_short_flag),
	.overpower_sink_en(overpower_sink_en), .overpower_charge_src(overpower_charge_src),
	.precharge_scale(precharge_scale), .input_current_monitor_out(input_current_monitor_out),
	.bias_enable(bias_enable), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// >>> tb/cps_selector_tb.sv
// Purpose: Self-checking bench for the protection selector.
// Assumes: Short timing: a millisecond is MS clocks.
// Notes:   Flags travel packed in fl, indexed by the constants.
`timescale 1ns/1ps
`default_nettype none
module cps_selector_tb;
	// ==========
	// Signals
	localparam int MS = 4, INS = 3, RAIL = 0, DLOW = 1, DGOOD = 2, OVP = 3, LOWC = 4, O104 = 5, B102 = 6;
	localparam int SHORT = 7, OC = 8, TS = 9, T135 = 10, LIM = 11, CAP = 12;
	logic        hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [12:0] fl;
	wire  [31:0] hrdata;
	wire         hready, asw, bsw, chg, hs, pre, bsf, dsk, mon, bias, gout, goe, pin;
	wire  [3:0]  step;
	wire  [5:0]  ob = {step == 4'h8, pin, hs, chg, bsw, asw};
	int          miscompares, n_checks, n;
	int          hy[6] = '{O104, B102, TS, T135, OC, RAIL};
	cps_selector #(.INSERT_MS(INS), .BLANK_MS(2), .TICK_CYC(MS)) dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(),
		.supply_rail_ok(fl[0]), .adapter_detect_low(fl[1]), .adapter_detect_good(fl[2]),
		.input_overvoltage(fl[3]), .input_low_clear(fl[4]), .battery_over_104(fl[5]), .battery_below_102(fl[6]),
		.battery_short_in(fl[7]), .charge_overcurrent(fl[8]), .thermal_shutdown(fl[9]),
		.thermal_below_135(fl[10]), .input_current_limit(fl[11]), .overpower_cap_2v(fl[12]),
		.adapter_switch_drive(asw), .battery_switch_drive(bsw), .charge_enable(chg), .hside_gate_enable(hs),
		.precharge_scale(pre), .battery_short_flag(bsf), .discharge_sink_en(dsk), .overpower_charge_src(),
		.overpower_sink_en(), .input_current_monitor_out(mon), .bias_enable(bias), .charge_target_step(step),
		.adapter_good_n_out(gout), .adapter_good_n_oe_n(goe));
	cps_far_side far_u (.good_out(gout), .good_oe_n(goe), .good_pin(pin));
	// ==========
	// Tasks
	task automatic tk(input int c);
		repeat (c) @(posedge hclk);
	endtask
	task automatic summarize();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] exp, got, input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Holds each phase until hready is sampled high or a bound of 50 cycles, shared by both phases, runs out.
	task automatic bus(input logic wr, input logic [31:0] a, wd, output logic [31:0] d);
		int k;
		k = 0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= a;
		do tk(1); while (hready !== 1'b1 && ++k < 50);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do tk(1); while (hready !== 1'b1 && ++k < 50);
		d = hrdata;
		chk(1, k < 50, "bus wait");
		if (k >= 50)
			summarize();
	endtask
	task automatic wt(input int b, input logic v);
		n = 0;
		while (ob[b] !== v && n < 400) begin
			tk(1);
			n++;
		end
		if (n >= 400) begin
			chk(v, ~v, "wait");
			summarize();
		end
	endtask
	// ==========
	// Stimulus
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		fl = 13'h0441;
		tk(4);
		hresetn <= 1'b1;
		tk(1);
		bus(1'b0, 32'h0, 32'h0, rd);
		chk(32'h0, rd, "ctrl reset");
		bus(1'b0, 32'h10, 32'h0, rd);
		chk(32'h0, rd, "unmapped");
		fl[RAIL] <= 1'b0;
		tk(3);
		chk(32'h0, {bias, mon}, "rail low");
		fl[RAIL] <= 1'b1;
		fl[DLOW] <= 1'b1;
		tk(3);
		chk(32'h2, {bias, mon}, "detect low");
		fl[DLOW] <= 1'b0;
		tk(3);
		chk(32'h3, {bias, mon}, "powered");
		// A one-cycle drop must restart the whole insertion delay.
		fl[DGOOD] <= 1'b1;
		tk(2 * MS);
		fl[DGOOD] <= 1'b0;
		tk(1);
		fl[DGOOD] <= 1'b1;
		chk(0, asw, "early switch");
		wt(4, 1'b0);
		chk(1, n >= (INS - 1) * MS && n <= (INS + 1) * MS + 3, "delay");
		chk(0, bsw, "battery off");
		wt(0, 1'b1);
		chk(1, n <= 2, "adapter on");
		fl[LIM] <= 1'b1;
		fl[CAP] <= 1'b1;
		tk(MS - 1);
		chk(1, asw, "blanked");
		wt(0, 1'b0);
		chk(1, n <= 2 * MS + 2, "latch");
		tk(2);
		chk(32'h1, {chg, bsw}, "latched path");
		bus(1'b0, 32'h4, 32'h0, rd);
		chk(1, rd[4], "latch bit");
		chk(1, rd[7], "bbm set");
		fl[LIM] <= 1'b0;
		fl[CAP] <= 1'b0;
		tk(4 * MS);
		chk(0, asw, "stays latched");
		fl[DGOOD] <= 1'b0;
		tk(2);
		fl[DGOOD] <= 1'b1;
		wt(0, 1'b1);
		bus(1'b1, 32'h0, 32'h1, rd);
		wt(5, 1'b1);
		chk(1, n >= 7 * MS && n <= 11 * MS + 4, "ramp");
		chk(32'h3, {chg, dsk}, "charging");
		fl[OVP] <= 1'b1;
		tk(3);
		chk(32'h2, {chg, bsw, asw}, "overvoltage");
		fl[OVP] <= 1'b0;
		wt(2, 1'b1);
		tk(1);
		chk(1, asw, "resumed");
		wt(3, 1'b1);
		for (int i = 0; i < 3; i++) begin
			fl[hy[2 * i]] <= 1'b1;
			if (i < 2)
				fl[hy[2 * i + 1]] <= 1'b0;
			tk(3);
			chk(0, hs, "gate off");
			fl[hy[2 * i]] <= 1'b0;
			tk(3);
			chk(i == 2, hs, "gate held");
			fl[hy[2 * i + 1]] <= 1'b1;
			wt(3, 1'b1);
		end
		bus(1'b1, 32'h0, 32'h3, rd);
		wt(1, 1'b1);
		fl[SHORT] <= 1'b1;
		wt(0, 1'b1);
		chk(32'h6, {pre, bsf, bsw}, "learn short");
		fl[SHORT] <= 1'b0;
		wt(1, 1'b1);
		chk(32'h0, {pre, bsf, asw}, "recovered");
		fl[LOWC] <= 1'b1;
		tk(3);
		chk(0, bsw, "low sense");
		bus(1'b0, 32'h4, 32'h0, rd);
		chk(0, rd[7], "bbm cleared");
		fl[LOWC] <= 1'b0;
		bus(1'b0, 32'h0, 32'h0, rd);
		chk(32'h3, rd, "ctrl");
		hresetn <= 1'b0;
		tk(2);
		chk(32'h8, {pin, asw, bsw, chg}, "lockout");
		summarize();
	end
endmodule // cps_selector_tb
`default_nettype wire
